// ===== cise_core.sv
// Execution unit for a subset of the byte-wide core's instruction set.
// Assumes code memory presents the three bytes at code_addr combinationally
// and that interrupt logic outside pulses the in-service entry inputs.
//
// Overview of operation
// RULE_01: Opcode A4 multiplies accumulator by product high, four cycles, low/high split.
// RULE_02: Multiply clears carry; signed range flag set when high byte nonzero.
// RULE_03: Idle opcode 00 takes one cycle and only advances program counter.
// RULE_04: Byte OR forms store per-bit OR in first operand only.
// RULE_05: Carry OR forms: bit into carry two cycles, complement one cycle.
// RULE_06: Stack unload copies RAM at stack pointer to direct, then decrements.
// RULE_07: Stack store increments stack pointer, then writes direct byte there.
// RULE_08: Subroutine exit pops high byte then low byte into program counter.
// RULE_09: Interrupt exit first re-enables its priority level, then pops counter; the code releases the level on the same step as the high-byte pop.
// RULE_10: Without interrupt in service, interrupt exit equals subroutine exit.
// RULE_11: Rotate left moves old bit 7 into bit 0.
// RULE_12: Rotate left through carry: bit 7 to carry, carry to bit 0.
// RULE_13: Rotate right moves bit 0 into bit 7, flags untouched.
// RULE_14: Rotate right through carry: bit 0 to carry, carry to bit 7.
// RULE_15: D3 sets carry; D2 sets addressed bit; both one cycle.
// RULE_16: Short branch adds signed offset to next instruction address, two cycles.
// RULE_17: Subtract forms write accumulator minus source to accumulator only.
// RULE_18: Incoming carry is subtracted as borrow-in.
// RULE_19: Carry set on borrow out of bit 7, else cleared.
// RULE_20: Half carry flag set on borrow out of bit 3, else cleared.
// RULE_21: Signed range flag set when exactly one of bit 6, bit 7 borrows.
// RULE_22: Nibble exchange swaps accumulator halves, flags untouched.
`timescale 1ns/10ps
`default_nettype none

module cise_core (
  input  wire logic        clk,
  input  wire logic        rstn,
  output logic [15:0]      code_addr,
  input  wire logic [7:0]  code_byte0,
  input  wire logic [7:0]  code_byte1,
  input  wire logic [7:0]  code_byte2,
  input  wire logic        isr_enter_high,
  input  wire logic        isr_enter_low,
  output logic [1:0]       in_service,
  output logic [7:0]       acc,
  output logic [7:0]       product_high_reg,
  output logic [7:0]       psw,
  output logic [7:0]       sp,
  output logic             retire,
  output logic             unsupported
);
  import cise_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [7:0]  ram [0:255];
  logic [7:0]  acc_r, acc_nxt, phigh_r, phigh_nxt, psw_r, psw_nxt;
  logic [7:0]  sp_r, sp_nxt, pc_hi_r, pc_hi_nxt;
  logic [15:0] pc_r, pc_nxt;
  logic [1:0]  isv_r;
  logic        retire_r, unsup_r, last, interrupt_exit_op_clr, bad_op;
  logic        ram_we;
  logic [7:0]  ram_wa, ram_wd;
  logic        wr_en;
  logic [7:0]  wr_a, wr_d;
  cise_state_t state_r, state_nxt;
  logic [7:0]  op, d1, d2, src, bit_byte;
  logic        bit_val, sub_b7, sub_b6, sub_b3;
  logic [8:0]  diff9;
  logic [15:0] mul_res, br_target;

  assign op = code_byte0;
  assign d1 = code_byte1;
  assign d2 = code_byte2;

  // ----------------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------------
  // Byte length of an opcode; unknown ones are stepped over as one byte
  function automatic logic [15:0] op_len(input logic [7:0] o);
    case (o)
      OP_OR_DIR_I:                                   op_len = 16'h0003;
      OP_OR_DIR_A, OP_OR_A_I, OP_OR_A_DIR, OP_OR_C_BIT, OP_OR_C_NBIT,
      OP_POP, OP_PUSH, OP_SET_BIT, OP_BRANCH, OP_SUB_I, OP_SUB_DIR:
                                                     op_len = 16'h0002;
      default:                                       op_len = 16'h0001;
    endcase
  endfunction

  // Last step index of an opcode
  function automatic cise_state_t op_last(input logic [7:0] o);
    case (o)
      OP_PRODUCT:                                    op_last = ST_C4;
      OP_OR_DIR_I, OP_OR_C_BIT, OP_POP, OP_PUSH, OP_EXIT_SUB, OP_EXIT_INT,
      OP_BRANCH:                                     op_last = ST_C2;
      default:                                       op_last = ST_EXEC;
    endcase
  endfunction

  // Opcodes this unit executes
  function automatic logic op_known(input logic [7:0] o);
    case (o)
      OP_IDLE, OP_RR, OP_RRC, OP_EXIT_SUB, OP_RL, OP_EXIT_INT, OP_RLC,
      OP_OR_DIR_A, OP_OR_DIR_I, OP_OR_A_I, OP_OR_A_DIR, OP_OR_A_IND0,
      OP_OR_A_IND1, OP_OR_C_BIT, OP_BRANCH, OP_SUB_I, OP_SUB_DIR,
      OP_SUB_IND0, OP_SUB_IND1, OP_OR_C_NBIT, OP_PRODUCT, OP_PUSH,
      OP_SWAP, OP_POP, OP_SET_BIT, OP_SET_C:         op_known = 1'b1;
      default: op_known = ((o >= OP_OR_A_R0) && (o <= OP_OR_A_R7)) ||
                          ((o >= OP_SUB_R0) && (o <= OP_SUB_R7));
    endcase
  endfunction

  // Direct-address read; unmodelled special registers read as zero
  function automatic logic [7:0] rd_dir(input logic [7:0] a);
    case (a)
      SFR_ACC:   rd_dir = acc_r;
      SFR_PHIGH: rd_dir = phigh_r;
      SFR_PSW:   rd_dir = psw_r;
      SFR_SP:    rd_dir = sp_r;
      default:   rd_dir = a[7] ? BYTE_ZERO : ram[a];
    endcase
  endfunction

  // Byte that holds an addressable bit
  function automatic logic [7:0] bit_home(input logic [7:0] a);
    bit_home = a[7] ? {a[7:3], 3'b000} : BIT_RAM_BASE + {4'h0, a[6:3]};
  endfunction

  // Bank register and indirect pointer reads
  function automatic logic [7:0] bank_reg(input logic [2:0] n);
    bank_reg = ram[{3'b000, psw_r[PSW_BANK_HI:PSW_BANK_LO], n}];
  endfunction

  // ----------------------------------------------------------------------
  // Operand and arithmetic paths
  // ----------------------------------------------------------------------
  // Source byte shared by OR and subtract forms; low opcode bits pick it
  always_comb begin
    if (op[3])
      src = bank_reg(op[2:0]);
    else if (op[2:0] == 3'b110 || op[2:0] == 3'b111)
      src = ram[bank_reg({2'b00, op[0]})];
    else if (op[2:0] == 3'b101)
      src = rd_dir(d1);
    else
      src = d1;
  end

  assign bit_byte = rd_dir(bit_home(d1));
  assign bit_val  = bit_byte[d1[2:0]];
  assign mul_res  = acc_r * phigh_r;
  // RULE_16: offset relative to next
  assign br_target = pc_r + 16'h0002 + {{8{d1[7]}}, d1};

  // Borrow chain with carry as borrow-in
  // RULE_18: carry is borrow-in
  assign diff9  = {1'b0, acc_r} - {1'b0, src} - {8'h00, psw_r[PSW_CY]};
  // RULE_19: borrow out of bit 7
  assign sub_b7 = diff9[8];
  // RULE_21: borrow out of bit 6
  assign sub_b6 = ({1'b0, acc_r[6:0]} - {1'b0, src[6:0]} - {7'h00, psw_r[PSW_CY]}) >> 7 != 8'h00;
  // RULE_20: borrow out of bit 3
  assign sub_b3 = ({1'b0, acc_r[3:0]} - {1'b0, src[3:0]} - {4'h0, psw_r[PSW_CY]}) >> 4 != 5'h00;

  // ----------------------------------------------------------------------
  // Execution step: next values of all architectural state except the in-service levels
  // ----------------------------------------------------------------------
  // Work is done on the step named per opcode; pc moves on the last step
  always_comb begin
    acc_nxt   = acc_r;
    phigh_nxt = phigh_r;
    psw_nxt   = psw_r;
    sp_nxt    = sp_r;
    pc_hi_nxt = pc_hi_r;
    wr_en     = 1'b0;
    wr_a      = d1;
    wr_d      = BYTE_ZERO;
    ram_we    = 1'b0;
    ram_wa    = sp_r;
    ram_wd    = BYTE_ZERO;
    interrupt_exit_op_clr  = 1'b0;
    last      = (state_r == op_last(op));
    bad_op    = !op_known(op);
    pc_nxt    = last ? pc_r + op_len(op) : pc_r;
    state_nxt = last ? ST_EXEC : cise_state_t'(state_r + 2'b01);
    case (op)
      // RULE_03: idle only advances pc
      OP_IDLE: begin
      end
      // RULE_01: product split on fourth cycle
      OP_PRODUCT: begin
        if (last) begin
          acc_nxt   = mul_res[7:0];
          phigh_nxt = mul_res[15:8];
          // RULE_02: carry and range flag
          psw_nxt[PSW_CY] = 1'b0;
          psw_nxt[PSW_OV] = |mul_res[15:8];
        end
      end
      // RULE_04: OR into direct byte
      OP_OR_DIR_A, OP_OR_DIR_I: begin
        if (last) begin
          wr_en = 1'b1;
          wr_d  = rd_dir(d1) | ((op == OP_OR_DIR_A) ? acc_r : d2);
        end
      end
      // RULE_05: carry OR forms
      OP_OR_C_BIT: begin
        if (last)
          psw_nxt[PSW_CY] = psw_r[PSW_CY] | bit_val;
      end
      OP_OR_C_NBIT: psw_nxt[PSW_CY] = psw_r[PSW_CY] | !bit_val;
      // RULE_06: read at pointer, then decrement
      OP_POP: begin
        if (state_r == ST_EXEC) begin
          wr_en = 1'b1;
          wr_d  = ram[sp_r];
        end else begin
          sp_nxt = sp_r - BYTE_ONE;
        end
      end
      // RULE_07: increment, then write
      OP_PUSH: begin
        if (state_r == ST_EXEC) begin
          sp_nxt = sp_r + BYTE_ONE;
        end else begin
          ram_we = 1'b1;
          ram_wd = rd_dir(d1);
        end
      end
      // RULE_08: high byte popped first
      // RULE_09: level released on the first step, with the high byte pop
      // RULE_10: same path as subroutine exit
      OP_EXIT_SUB, OP_EXIT_INT: begin
        sp_nxt = sp_r - BYTE_ONE;
        if (state_r == ST_EXEC) begin
          pc_hi_nxt = ram[sp_r];
          interrupt_exit_op_clr  = (op == OP_EXIT_INT);
        end else begin
          pc_nxt = {pc_hi_r, ram[sp_r]};
        end
      end
      // RULE_11: rotate left
      OP_RL: acc_nxt = {acc_r[6:0], acc_r[7]};
      // RULE_12: rotate left through carry
      OP_RLC: begin
        acc_nxt         = {acc_r[6:0], psw_r[PSW_CY]};
        psw_nxt[PSW_CY] = acc_r[7];
      end
      // RULE_13: rotate right
      OP_RR: acc_nxt = {acc_r[0], acc_r[7:1]};
      // RULE_14: rotate right through carry
      OP_RRC: begin
        acc_nxt         = {psw_r[PSW_CY], acc_r[7:1]};
        psw_nxt[PSW_CY] = acc_r[0];
      end
      // RULE_15: set carry or addressed bit
      OP_SET_C: psw_nxt[PSW_CY] = 1'b1;
      OP_SET_BIT: begin
        wr_en = 1'b1;
        wr_a  = bit_home(d1);
        wr_d  = bit_byte | (BYTE_ONE << d1[2:0]);
      end
      // RULE_16: branch on second cycle
      OP_BRANCH: begin
        if (last)
          pc_nxt = br_target;
      end
      // RULE_22: nibble exchange
      OP_SWAP: acc_nxt = {acc_r[3:0], acc_r[7:4]};
      default: begin
        // RULE_04: OR into accumulator
        if (op >= OP_OR_A_I && op <= OP_OR_A_R7) begin
          acc_nxt = acc_r | src;
        end else if (op >= OP_SUB_I && op <= OP_SUB_R7) begin
          // RULE_17: difference to accumulator
          acc_nxt         = diff9[7:0];
          psw_nxt[PSW_CY] = sub_b7;
          psw_nxt[PSW_AC] = sub_b3;
          psw_nxt[PSW_OV] = sub_b6 ^ sub_b7;
        end
      end
    endcase
    // Direct writes land on a special register or lower RAM
    if (wr_en) begin
      case (wr_a)
        SFR_ACC:   acc_nxt   = wr_d;
        SFR_PHIGH: phigh_nxt = wr_d;
        SFR_PSW:   psw_nxt   = wr_d;
        SFR_SP:    sp_nxt    = wr_d;
        default: begin
          ram_we = !wr_a[7];
          ram_wa = wr_a;
          ram_wd = wr_d;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Accumulator and product high byte
  always_ff @(posedge clk) begin
    if (!rstn) begin
      acc_r   <= BYTE_ZERO;
      phigh_r <= BYTE_ZERO;
    end else begin
      acc_r   <= acc_nxt;
      phigh_r <= phigh_nxt;
    end
  end

  // Flags, stack pointer, program counter
  always_ff @(posedge clk) begin
    if (!rstn) begin
      psw_r   <= BYTE_ZERO;
      sp_r    <= SP_RESET;
      pc_r    <= PC_RESET;
      pc_hi_r <= BYTE_ZERO;
    end else begin
      psw_r   <= psw_nxt;
      sp_r    <= sp_nxt;
      pc_r    <= pc_nxt;
      pc_hi_r <= pc_hi_nxt;
    end
  end

  // Step counter and end-of-instruction pulses
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r  <= ST_EXEC;
      retire_r <= 1'b0;
      unsup_r  <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      retire_r <= last;
      unsup_r  <= last && bad_op;
    end
  end

  // Internal RAM; data only, so no reset
  always_ff @(posedge clk) begin
    if (ram_we)
      ram[ram_wa] <= ram_wd;
  end

  // In-service levels; a new entry wins over a release in the same cycle
  always_ff @(posedge clk) begin
    if (!rstn) begin
      isv_r <= 2'b00;
    end else begin
      // RULE_09: release highest active level
      if (interrupt_exit_op_clr)
        isv_r <= (isv_r[1] ? {1'b0, isv_r[0]} : 2'b00) | {isr_enter_high, isr_enter_low};
      else
        isv_r <= isv_r | {isr_enter_high, isr_enter_low};
    end
  end

  assign code_addr        = pc_r;
  assign acc              = acc_r;
  assign product_high_reg = phigh_r;
  assign psw              = psw_r;
  assign sp               = sp_r;
  assign in_service       = isv_r;
  assign retire           = retire_r;
  assign unsupported      = unsup_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic start;
  assign start = (state_r == ST_EXEC);

  a_mul_duration: assert property (@(posedge clk) disable iff (!rstn) // RULE_01
    (start && op == OP_PRODUCT) |=> !retire_r [*3] ##1 retire_r)
    else $error("multiply did not take four cycles");

  a_mul_flags: assert property (@(posedge clk) disable iff (!rstn) // RULE_02
    (state_r == ST_C4 && op == OP_PRODUCT) |=>
      ({phigh_r, acc_r} == $past(mul_res)) && !psw_r[PSW_CY] && (psw_r[PSW_OV] == (phigh_r != 8'h00)))
    else $error("multiply result or flags wrong");

  a_idle_effect: assert property (@(posedge clk) disable iff (!rstn) // RULE_03
    (start && op == OP_IDLE) |=>
      pc_r == $past(pc_r) + 16'h0001 && $stable(acc_r) && $stable(psw_r) && $stable(sp_r))
    else $error("idle changed state");

  a_push_order: assert property (@(posedge clk) disable iff (!rstn) // RULE_07
    (start && op == OP_PUSH) |=> sp_r == $past(sp_r) + 8'h01 && ram_we && ram_wa == sp_r)
    else $error("stack store order wrong");

  a_pop_sp: assert property (@(posedge clk) disable iff (!rstn) // RULE_06
    (start && op == OP_POP && d1 != SFR_SP) |=> ##1 sp_r == $past(sp_r, 2) - 8'h01)
    else $error("stack unload pointer wrong");

  a_exit_pc: assert property (@(posedge clk) disable iff (!rstn) // RULE_08
    (start && (op == OP_EXIT_SUB || op == OP_EXIT_INT)) |=>
      ##1 pc_r[15:8] == $past(ram[sp_r], 2) && sp_r == $past(sp_r, 2) - 8'h02)
    else $error("exit did not restore counter high byte first");

  a_interrupt_exit_op_release: assert property (@(posedge clk) disable iff (!rstn) // RULE_09
    (start && op == OP_EXIT_INT && isv_r == 2'b11 && !isr_enter_high) |=> !isv_r[1])
    else $error("interrupt exit kept its level");

  a_rotate_right: assert property (@(posedge clk) disable iff (!rstn) // RULE_13
    (start && op == OP_RR) |=> acc_r == {$past(acc_r[0]), $past(acc_r[7:1])} && $stable(psw_r))
    else $error("rotate right wrong");

  a_branch_target: assert property (@(posedge clk) disable iff (!rstn) // RULE_16
    (start && op == OP_BRANCH) |=> ##1 pc_r == $past(br_target, 2))
    else $error("short branch target wrong");

  a_sub_carry: assert property (@(posedge clk) disable iff (!rstn) // RULE_19
    (start && op >= OP_SUB_I && op <= OP_SUB_R7) |=>
      psw_r[PSW_CY] == ($past({1'b0, acc_r}) < $past({1'b0, src}) + $past({8'h00, psw_r[PSW_CY]})))
    else $error("subtract borrow flag wrong");

  a_swap_nibble: assert property (@(posedge clk) disable iff (!rstn) // RULE_22
    (start && op == OP_SWAP) |=> acc_r == {$past(acc_r[3:0]), $past(acc_r[7:4])} && $stable(psw_r))
    else $error("nibble exchange wrong");

endmodule

`default_nettype wire

// ===== cise_pkg.sv
// Package for the instruction subset execution unit: opcodes, special
// register addresses, flag positions, reset values and state codes.
// Assumes a byte-wide core with 16-bit program counter and 256-byte RAM.
package cise_pkg;

  // ----------------------------------------------------------------------
  // Opcodes of the executed subset
  // ----------------------------------------------------------------------
  localparam logic [7:0] OP_IDLE      = 8'h00;
  localparam logic [7:0] OP_RR        = 8'h03;
  localparam logic [7:0] OP_RRC       = 8'h13;
  localparam logic [7:0] OP_EXIT_SUB  = 8'h22;
  localparam logic [7:0] OP_RL        = 8'h23;
  localparam logic [7:0] OP_EXIT_INT  = 8'h32;
  localparam logic [7:0] OP_RLC       = 8'h33;
  localparam logic [7:0] OP_OR_DIR_A  = 8'h42;
  localparam logic [7:0] OP_OR_DIR_I  = 8'h43;
  localparam logic [7:0] OP_OR_A_I    = 8'h44;
  localparam logic [7:0] OP_OR_A_DIR  = 8'h45;
  localparam logic [7:0] OP_OR_A_IND0 = 8'h46;
  localparam logic [7:0] OP_OR_A_IND1 = 8'h47;
  localparam logic [7:0] OP_OR_A_R0   = 8'h48;
  localparam logic [7:0] OP_OR_A_R7   = 8'h4F;
  localparam logic [7:0] OP_OR_C_BIT  = 8'h72;
  localparam logic [7:0] OP_BRANCH    = 8'h80;
  localparam logic [7:0] OP_SUB_I     = 8'h94;
  localparam logic [7:0] OP_SUB_DIR   = 8'h95;
  localparam logic [7:0] OP_SUB_IND0  = 8'h96;
  localparam logic [7:0] OP_SUB_IND1  = 8'h97;
  localparam logic [7:0] OP_SUB_R0    = 8'h98;
  localparam logic [7:0] OP_SUB_R7    = 8'h9F;
  localparam logic [7:0] OP_OR_C_NBIT = 8'hA0;
  localparam logic [7:0] OP_PRODUCT   = 8'hA4;
  localparam logic [7:0] OP_PUSH      = 8'hC0;
  localparam logic [7:0] OP_SWAP      = 8'hC4;
  localparam logic [7:0] OP_POP       = 8'hD0;
  localparam logic [7:0] OP_SET_BIT   = 8'hD2;
  localparam logic [7:0] OP_SET_C     = 8'hD3;

  // ----------------------------------------------------------------------
  // Special register addresses, flag positions, reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] SFR_SP       = 8'h81;
  localparam logic [7:0] SFR_PSW      = 8'hD0;
  localparam logic [7:0] SFR_ACC      = 8'hE0;
  localparam logic [7:0] SFR_PHIGH    = 8'hF0;
  localparam logic [7:0] BIT_RAM_BASE = 8'h20;
  localparam int         PSW_CY       = 7;
  localparam int         PSW_AC       = 6;
  localparam int         PSW_BANK_HI  = 4;
  localparam int         PSW_BANK_LO  = 3;
  localparam int         PSW_OV       = 2;
  localparam logic [7:0] SP_RESET     = 8'h07;
  localparam logic [7:0] BYTE_ZERO    = 8'h00;
  localparam logic [7:0] BYTE_ONE     = 8'h01;
  localparam logic [15:0] PC_RESET    = 16'h0000;

  // Execution step within a multi-cycle instruction
  typedef enum logic [1:0] {
    ST_EXEC = 2'b00,
    ST_C2   = 2'b01,
    ST_C3   = 2'b10,
    ST_C4   = 2'b11
  } cise_state_t;

endpackage

// ===== cise_core_tb.sv
// Self-checking bench for the instruction subset unit: code memory,
// reference model and retire-ordered checks. Assumes cise_pkg, cise_core.
`timescale 1ns/10ps
`default_nettype none
module cise_core_tb;
  import cise_pkg::*;
  typedef struct {logic [7:0] a, b, p, s; logic [15:0] pc; logic [1:0] iv; logic un; int cy;} cise_exp_t;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  code_byte0 = 8'h00;
  logic [7:0]  code_byte1 = 8'h00;
  logic [7:0]  code_byte2 = 8'h00;
  logic        isr_enter_low = 1'b0;
  logic        isr_enter_high = 1'b0;
  logic [15:0] code_addr;
  logic [1:0]  in_service;
  logic [7:0]  acc, product_high_reg, psw, sp;
  logic        retire, unsupported;
  logic [7:0]  prog [0:1023];
  logic [7:0]  ram [0:255];
  logic [7:0]  m_a = 8'h00, m_b = 8'h00, m_p = 8'h00, m_s = 8'h07;
  logic [15:0] m_pc = 16'h0000;
  logic [1:0]  m_iv = 2'b11;
  logic [31:0] rnd = 32'h0000_20a3;
  logic [7:0]  rots [6] = '{OP_RL, OP_RLC, OP_RR, OP_RRC, OP_SWAP, OP_SET_C};
  cise_exp_t   q[$];
  int          err_total = 0, checks = 0, cnt = 0, last = 0;

  always #20 clk = ~clk;

  cise_core dut_u (.clk(clk), .rstn(rstn), .code_addr(code_addr), .code_byte0(code_byte0),
    .code_byte1(code_byte1), .code_byte2(code_byte2), .isr_enter_high(isr_enter_high),
    .isr_enter_low(isr_enter_low), .in_service(in_service), .acc(acc),
    .product_high_reg(product_high_reg), .psw(psw), .sp(sp), .retire(retire), .unsupported(unsupported));

  // ----------------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------------
  function automatic logic [7:0] rn();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd[7:0];
  endfunction
  function automatic logic [7:0] rd(input logic [7:0] d);
    case (d)
      SFR_ACC:   return m_a;
      SFR_PHIGH: return m_b;
      SFR_PSW:   return m_p;
      SFR_SP:    return m_s;
      default:   return (d < 8'h80) ? ram[d] : 8'h00;
    endcase
  endfunction
  task automatic wr(input logic [7:0] d, input logic [7:0] v);
    case (d)
      SFR_ACC:   m_a = v;
      SFR_PHIGH: m_b = v;
      SFR_PSW:   m_p = v;
      SFR_SP:    m_s = v;
      default:   if (d < 8'h80) ram[d] = v;
    endcase
  endtask
  function automatic logic [7:0] ba(input logic [7:0] a);
    return (a < 8'h80) ? 8'h20 + a[6:3] : {a[7:3], 3'b000};
  endfunction
  task automatic sub(input logic [7:0] s);
    logic [8:0] f;
    logic [4:0] h;
    logic [7:0] l;
    f = {1'b0, m_a} - s - m_p[7];
    h = {1'b0, m_a[3:0]} - s[3:0] - m_p[7];
    l = {1'b0, m_a[6:0]} - s[6:0] - m_p[7];
    m_p[7] = f[8];
    m_p[6] = h[4];
    m_p[2] = f[8] ^ l[7];
    m_a = f[7:0];
  endtask
  // Places one instruction in code memory and notes its expected effect
  task automatic op(input logic [7:0] o, input logic [7:0] x, input logic [7:0] y, input int n, input int cy);
    logic [15:0] pr;
    logic        un;
    logic [9:0]  ix;
    ix = m_pc[9:0];
    prog[ix] = o;
    prog[ix + 10'd1] = x;
    prog[ix + 10'd2] = y;
    un = 1'b0;
    m_pc = m_pc + 16'(n);
    case (o)
      8'hA5:        un = 1'b1;
      OP_PRODUCT:   begin
        pr = m_a * m_b;
        {m_b, m_a} = pr;
        m_p[7] = 1'b0;
        m_p[2] = |pr[15:8];
      end
      OP_OR_DIR_A:  wr(x, rd(x) | m_a);
      OP_OR_DIR_I:  wr(x, rd(x) | y);
      OP_OR_A_I:    m_a = m_a | x;
      OP_OR_A_DIR:  m_a = m_a | rd(x);
      8'h4B:        m_a = m_a | ram[{3'b000, m_p[4:3], 3'd3}];
      OP_OR_C_BIT:  m_p[7] = m_p[7] | (|(rd(ba(x)) & (8'h01 << x[2:0])));
      OP_OR_C_NBIT: m_p[7] = m_p[7] | ~(|(rd(ba(x)) & (8'h01 << x[2:0])));
      OP_POP:       begin
        pr[7:0] = ram[m_s];
        m_s = m_s - 8'h01;
        wr(x, pr[7:0]);
      end
      OP_PUSH:      begin
        m_s = m_s + 8'h01;
        ram[m_s] = rd(x);
      end
      OP_EXIT_SUB, OP_EXIT_INT: begin
        if (o == OP_EXIT_INT && m_iv[1]) m_iv[1] = 1'b0;
        else if (o == OP_EXIT_INT) m_iv[0] = 1'b0;
        m_pc = {ram[m_s], ram[m_s - 8'h01]};
        m_s = m_s - 8'h02;
      end
      OP_RL:        m_a = {m_a[6:0], m_a[7]};
      OP_RLC:       {m_p[7], m_a} = {m_a, m_p[7]};
      OP_RR:        m_a = {m_a[0], m_a[7:1]};
      OP_RRC:       {m_a, m_p[7]} = {m_p[7], m_a};
      OP_SWAP:      m_a = {m_a[3:0], m_a[7:4]};
      OP_SET_C:     m_p[7] = 1'b1;
      OP_SET_BIT:   wr(ba(x), rd(ba(x)) | (8'h01 << x[2:0]));
      OP_BRANCH:    m_pc = m_pc + {{8{x[7]}}, x};
      OP_SUB_I:     sub(x);
      OP_SUB_DIR:   sub(rd(x));
      8'h9B:        sub(ram[{3'b000, m_p[4:3], 3'd3}]);
      default:      ;
    endcase
    q.push_back('{m_a, m_b, m_p, m_s, m_pc, m_iv, un, cy});
  endtask
  // Clear carry by a multiply, zero the accumulator, then load it
  task automatic lda(input logic [7:0] v);
    op(OP_PRODUCT, 8'h00, 8'h00, 1, 4);
    op(OP_SUB_DIR, SFR_ACC, 8'h00, 2, 1);
    op(OP_OR_A_I, v, 8'h00, 2, 1);
  endtask
  // Return address pushed low byte first, as a call would leave it
  task automatic ret_to(input logic [7:0] o);
    logic [15:0] t;
    t = m_pc + 16'h0028;
    lda(t[7:0]);
    op(OP_PUSH, SFR_ACC, 8'h00, 2, 2);
    lda(t[15:8]);
    op(OP_PUSH, SFR_ACC, 8'h00, 2, 2);
    op(o, 8'h00, 8'h00, 1, 2);
  endtask

  // ----------------------------------------------------------------------
  // Code memory and retire monitor
  // ----------------------------------------------------------------------
  always @(negedge clk) begin
    code_byte0 <= prog[code_addr[9:0]];
    code_byte1 <= prog[code_addr[9:0] + 10'd1];
    code_byte2 <= prog[code_addr[9:0] + 10'd2];
  end
  always @(posedge clk) cnt <= rstn ? cnt + 1 : 0;
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Oldest note is compared whenever an instruction retires
  always @(negedge clk) begin
    cise_exp_t e;
    if (rstn && retire === 1'b1 && q.size() > 0) begin
      e = q.pop_front();
      chk8(acc, e.a);
      chk8(product_high_reg, e.b);
      chk8(psw, e.p);
      chk8(sp, e.s);
      chk16(code_addr, e.pc);
      chk8({6'b0, in_service}, {6'b0, e.iv});
      chk8({7'b0, unsupported}, {7'b0, e.un});
      chk8(8'(cnt - last), 8'(e.cy));
      last = cnt;
    end
  end

  task automatic end_sim();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Program, reset and run
  // ----------------------------------------------------------------------
  initial begin
    for (int i = 0; i < 1024; i++) prog[i] = OP_IDLE;
    lda(rn());
    op(OP_OR_DIR_A, SFR_PHIGH, 8'h00, 2, 1);
    op(OP_OR_A_I, rn(), 8'h00, 2, 1);
    op(OP_PRODUCT, 8'h00, 8'h00, 1, 4);
    op(OP_OR_DIR_I, SFR_PHIGH, rn(), 3, 2);
    op(OP_OR_A_DIR, SFR_PHIGH, 8'h00, 2, 1);
    op(OP_OR_C_BIT, 8'hF3, 8'h00, 2, 2);
    op(OP_OR_C_NBIT, 8'hF5, 8'h00, 2, 1);
    for (int i = 0; i < 12; i++) op(rots[i % 6], 8'h00, 8'h00, 1, 1);
    op(OP_IDLE, 8'h00, 8'h00, 1, 1);
    op(8'hA5, 8'h00, 8'h00, 1, 1);
    op(OP_PUSH, SFR_ACC, 8'h00, 2, 2);
    op(OP_POP, 8'h03, 8'h00, 2, 2);
    op(8'h4B, 8'h00, 8'h00, 1, 1);
    for (int i = 0; i < 6; i++) begin
      op(OP_SUB_I, rn(), 8'h00, 2, 1);
      op(8'h9B, 8'h00, 8'h00, 1, 1);
      op(OP_SET_BIT, 8'hD7, 8'h00, 2, 1);
    end
    ret_to(OP_EXIT_INT);
    ret_to(OP_EXIT_INT);
    ret_to(OP_EXIT_SUB);
    // Furthest forward, then furthest back into the skipped gap
    op(OP_BRANCH, 8'h7F, 8'h00, 2, 2);
    op(OP_SWAP, 8'h00, 8'h00, 1, 1);
    op(OP_BRANCH, 8'h80, 8'h00, 2, 2);
    op(OP_BRANCH, 8'h00, 8'h00, 2, 2);
    op(OP_RL, 8'h00, 8'h00, 1, 1);
    repeat (7) @(negedge clk);
    rstn <= 1'b1;
    isr_enter_low <= 1'b1;
    isr_enter_high <= 1'b1;
    @(negedge clk);
    isr_enter_low <= 1'b0;
    isr_enter_high <= 1'b0;
    for (int i = 0; i < 4000 && q.size() > 0; i++) @(negedge clk);
    if (q.size() > 0) err_total++;
    end_sim();
  end
  // Watchdog well beyond the expected program length
  initial begin
    #(6000 * 40);
    err_total++;
    end_sim();
  end
endmodule
`default_nettype wire
